// [hdl/dccs_cal_seq.sv]
// Channel calibration sequencer with AXI4-Lite register access.
// Assumes pins arrive asynchronously and a neighbour block does the curve fit.
`timescale 1ns/1ps
module dccs_cal_seq
    import dccs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire dccs_pins_t pinsIn,
    output dccs_apply_t applyOut,
    output dccs_route_t routeOut
);
    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_CMD || a == ADDR_VALUE || a == ADDR_REPLY ||
               a == ADDR_STATUS || a == ADDR_CURCAL || a == ADDR_VOLCAL;
    endfunction

    dccs_pins_t pinsS1_ff;
    dccs_pins_t pinsS2_ff;
    logic awPend_ff;
    logic [7:0] awAddr_ff;
    logic wPend_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;
    logic rValid_ff;
    logic [31:0] rData_ff;
    logic [1:0] rResp_ff;
    logic pathChan_ff;
    logic [31:0] value_ff;
    logic [15:0] reply_ff;
    logic err_ff;
    dccs_state_t state_ff;
    logic [3:0] chan_ff;
    logic [5:0] cnt_ff;
    logic [DCCS_NCH-1:0] curCal_ff;
    logic [DCCS_NCH-1:0] volCal_ff;
    dccs_apply_t apply_ff;
    dccs_route_t route_ff;

    // Both flops of the synchroniser run as one; only the second is read
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pinsS1_ff <= '0;
            pinsS2_ff <= '0;
        end else begin
            pinsS1_ff <= pinsIn;
            pinsS2_ff <= pinsS1_ff;
        end
    end

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire haveAw = awPend_ff || awTake;
    wire haveW = wPend_ff || wTake;
    wire wrDo = haveAw && haveW && !bValid_ff;
    wire [7:0] wrAddr = awPend_ff ? awAddr_ff : s_axi_awaddr;
    wire [31:0] wrData = wPend_ff ? wData_ff : s_axi_wdata;
    wire [3:0] wrStrb = wPend_ff ? wStrb_ff : s_axi_wstrb;
    wire arTake = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !awPend_ff && !bValid_ff;
    assign s_axi_wready = !wPend_ff && !bValid_ff;
    assign s_axi_arready = !rValid_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;
    assign applyOut = apply_ff;
    assign routeOut = route_ff;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            awPend_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wPend_ff <= 1'b0;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
            bValid_ff <= 1'b0;
            bResp_ff <= RESP_OKAY;
        end else begin
            awPend_ff <= haveAw && !wrDo;
            wPend_ff <= haveW && !wrDo;
            if (awTake) begin
                awAddr_ff <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (wrDo) begin
                bValid_ff <= 1'b1;
                bResp_ff <= mapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bValid_ff <= 1'b0;
            end
        end
    end

    wire [31:0] statusWord = {16'h0000, 2'h0, cnt_ff, 5'h00, state_ff, err_ff};
    wire [31:0] rdMux =
        (s_axi_araddr == ADDR_CTRL) ? {31'h00000000, pathChan_ff} :
        (s_axi_araddr == ADDR_VALUE) ? value_ff :
        (s_axi_araddr == ADDR_REPLY) ? {16'h0000, reply_ff} :
        (s_axi_araddr == ADDR_STATUS) ? statusWord :
        (s_axi_araddr == ADDR_CURCAL) ? {16'h0000, curCal_ff} :
        (s_axi_araddr == ADDR_VOLCAL) ? {16'h0000, volCal_ff} : 32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rValid_ff <= 1'b0;
            rData_ff <= 32'h00000000;
            rResp_ff <= RESP_OKAY;
        end else if (arTake) begin
            rValid_ff <= 1'b1;
            rData_ff <= rdMux;
            rResp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    // Command decode; a write to the command word is the command itself
    wire cmdFire = wrDo && wrAddr == ADDR_CMD;
    wire [2:0] cmdOp = wrData[CMD_OP_LSB +: 3];
    wire [4:0] cmdCh = wrData[CMD_CH_LSB +: 5];
    wire [3:0] cmdIdx = 4'(cmdCh - 5'h01);
    wire chOk = cmdCh != 5'h00 && cmdCh <= (pinsS2_ff.wideBuild ? CH_MAX_WIDE : CH_MAX_NARROW);
    wire jmpCur = pinsS2_ff.progSel[cmdIdx] || !pinsS2_ff.outIsVolt[cmdIdx];
    wire jmpVol = pinsS2_ff.progSel[cmdIdx] || pinsS2_ff.outIsVolt[cmdIdx];
    wire [5:0] cntInc = cnt_ff + 6'h01;
    wire resOk = pinsS2_ff.resCalibrated;

    dccs_state_t nxt_state;
    logic [3:0] nxt_chan;
    logic [5:0] nxt_cnt;
    logic [15:0] nxt_reply;
    logic nxt_errSet;
    logic nxt_done;

    always_comb begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_cnt = cnt_ff;
        nxt_reply = reply_ff;
        nxt_errSet = 1'b0;
        nxt_done = 1'b0;
        if (cmdFire) begin
            // every command leaves idle unless it starts or keeps a calibration going
            nxt_state = ST_IDLE;
            nxt_cnt = 6'h00;
            unique case (cmdOp)
                OP_CFG_CUR, OP_CFG_VOL: begin
                    nxt_reply = RPL_NOT_READY;
                    // reject while waiting for trigger or bad index
                    if (!chOk || pinsS2_ff.trigWaiting) begin
                        nxt_errSet = 1'b1;
                    end else if (cmdOp == OP_CFG_CUR ? jmpCur : jmpVol) begin
                        nxt_reply = RPL_READY;
                        nxt_state = (cmdOp == OP_CFG_CUR) ? ST_CUR : ST_VOL;
                        nxt_chan = cmdIdx;
                    end else begin
                        nxt_errSet = 1'b1;
                    end
                end
                OP_ENT_CUR, OP_ENT_VOL: begin
                    nxt_reply = RPL_ABORT;
                    if (!chOk) begin
                        nxt_errSet = 1'b1;
                    end
                    if (chOk && cmdIdx == chan_ff && !pinsS2_ff.resCalActive &&
                        state_ff == (cmdOp == OP_ENT_CUR ? ST_CUR : ST_VOL) &&
                        cntInc <= MAX_ENTRIES) begin
                        if (cntInc >= MIN_ENTRIES && pinsS2_ff.fitConverged) begin
                            nxt_done = 1'b1;
                            nxt_reply = (cmdOp == OP_ENT_VOL || resOk) ? RPL_DONE_RES
                                                                       : RPL_DONE_NORES;
                        end else begin
                            nxt_state = state_ff;
                            nxt_cnt = cntInc;
                            nxt_reply = (cmdOp == OP_ENT_VOL || resOk) ? RPL_MORE_RES
                                                                       : RPL_MORE_NORES;
                        end
                    end
                end
                default: begin
                    nxt_reply = reply_ff;
                end
            endcase
        end
    end

    // Routing follows the next state so relays move with the reply
    wire nxt_active = nxt_state != ST_IDLE;
    wire nxt_path = (wrDo && wrAddr == ADDR_CTRL && wrStrb[0]) ? wrData[CTRL_PATH_BIT]
                                                             : pathChan_ff;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pathChan_ff <= 1'b0;
            value_ff <= 32'h00000000;
            reply_ff <= RPL_NOT_READY;
            err_ff <= 1'b0;
            state_ff <= ST_IDLE;
            chan_ff <= 4'h0;
            cnt_ff <= 6'h00;
            curCal_ff <= '0;
            volCal_ff <= '0;
            apply_ff <= '0;
            route_ff <= '0;
        end else begin
            pathChan_ff <= nxt_path;
            if (wrDo && wrAddr == ADDR_VALUE) begin
                value_ff <= mergeStrb(value_ff, wrData, wrStrb);
            end
            reply_ff <= nxt_reply;
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            cnt_ff <= nxt_cnt;
            // Write one clears the error; a new error in the same cycle wins
            err_ff <= nxt_errSet || (err_ff && !(wrDo && wrAddr == ADDR_STATUS &&
                                                 wrStrb[0] && wrData[STAT_ERR_BIT]));
            // constants go to working use only
            apply_ff.strobe <= nxt_done;
            if (nxt_done) begin
                apply_ff.isVolt <= state_ff == ST_VOL;
                apply_ff.chan <= chan_ff;
                apply_ff.lastValue <= value_ff;
            end
            // status words; current flag needs a calibrated resistor
            if (nxt_done && state_ff == ST_VOL) begin
                volCal_ff[chan_ff] <= 1'b1;
            end
            if (nxt_done && state_ff == ST_CUR) begin
                curCal_ff[chan_ff] <= resOk;
            end
            route_ff.sharedConnect <= nxt_active && !nxt_path;
            route_ff.chanClose <= (nxt_active && nxt_path) ? (16'h0001 << nxt_chan) : 16'h0000;
        end
    end

    property p_cfg_ready;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmdOp == OP_CFG_VOL && chOk && !pinsS2_ff.trigWaiting && jmpVol
        |=> reply_ff == RPL_READY && state_ff == ST_VOL;
    endproperty
    a_cfg_ready: assert property (p_cfg_ready) else $error("configure not ready");

    property p_bad_chan;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmdOp == OP_CFG_CUR && !chOk |=> err_ff && state_ff == ST_IDLE;
    endproperty
    a_bad_chan: assert property (p_bad_chan) else $error("bad channel accepted");

    property p_trig;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmdOp == OP_CFG_CUR && pinsS2_ff.trigWaiting
        |=> err_ff && reply_ff == RPL_NOT_READY;
    endproperty
    a_trig: assert property (p_trig) else $error("configure during trigger wait");

    property p_jumper;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmdOp == OP_CFG_CUR && chOk && !pinsS2_ff.trigWaiting &&
        !pinsS2_ff.progSel[cmdIdx] && pinsS2_ff.outIsVolt[cmdIdx] |=> state_ff == ST_IDLE;
    endproperty
    a_jumper: assert property (p_jumper) else $error("jumper ignored");

    property p_route_shared;
        @(posedge clk_sys) disable iff (!resetn)
        state_ff != ST_IDLE && !pathChan_ff |-> route_ff.sharedConnect &&
        route_ff.chanClose == 16'h0000;
    endproperty
    a_route_shared: assert property (p_route_shared) else $error("shared route");

    property p_route_chan;
        @(posedge clk_sys) disable iff (!resetn)
        state_ff != ST_IDLE && pathChan_ff |-> !route_ff.sharedConnect &&
        route_ff.chanClose[chan_ff] && $onehot(route_ff.chanClose);
    endproperty
    a_route_chan: assert property (p_route_chan) else $error("channel route");

    property p_min;
        @(posedge clk_sys) disable iff (!resetn)
        apply_ff.strobe |-> $past(cnt_ff) >= 6'h08;
    endproperty
    a_min: assert property (p_min) else $error("completed too early");

    property p_mismatch;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmdOp == OP_ENT_CUR && state_ff == ST_VOL
        |=> reply_ff == RPL_ABORT && state_ff == ST_IDLE;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("no abort on mismatch");

    property p_max;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && (cmdOp == OP_ENT_CUR || cmdOp == OP_ENT_VOL) && cnt_ff == MAX_ENTRIES
        |=> reply_ff == RPL_ABORT && cnt_ff == 6'h00;
    endproperty
    a_max: assert property (p_max) else $error("no abort past limit");

    property p_nores;
        @(posedge clk_sys) disable iff (!resetn)
        apply_ff.strobe && !apply_ff.isVolt && !$past(resOk) |-> !curCal_ff[apply_ff.chan];
    endproperty
    a_nores: assert property (p_nores) else $error("flag set without resistor");

    property p_other;
        @(posedge clk_sys) disable iff (!resetn)
        cmdFire && cmdOp == OP_OTHER |=> state_ff == ST_IDLE && !apply_ff.strobe &&
        $stable(curCal_ff) && $stable(volCal_ff);
    endproperty
    a_other: assert property (p_other) else $error("interruption not discarded");

    property p_idle;
        @(posedge clk_sys) disable iff (!resetn)
        state_ff == ST_IDLE |-> cnt_ff == 6'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("counter kept in idle");

    c_done_vol: cover property (@(posedge clk_sys) apply_ff.strobe && apply_ff.isVolt);
    c_done_cur: cover property (@(posedge clk_sys) apply_ff.strobe && !apply_ff.isVolt);
    c_abort: cover property (@(posedge clk_sys) cmdFire ##1 reply_ff == RPL_ABORT);
    c_route: cover property (@(posedge clk_sys) route_ff.chanClose != 16'h0000);
endmodule // dccs_cal_seq

// [shared/dccs_pkg.sv]
// Contract
// - Channel index 1..8, or 1..16 on wide builds; anything else flags an error.
// - Configure request replies 16-bit 1 when ready, 0 when not.
// - Shared path (reset default) feeds shared terminals and opens all channel outputs.
// - Per-channel path feeds selected channel terminals; shared terminals disconnected.
// - Configure request while trigger waits is rejected with an error.
// - Current configure needs program-selectable jumper or output-type jumper at current.
// - Voltage configure needs program-selectable jumper or output-type jumper at voltage.
// - At least nine entries before completion; host ready for up to fifty.
// - Current entry codes 0,1,2,3 by completion and resistor state; 5 abort.
// - Voltage entry codes: 0 complete, 1 more needed, 5 abort.
// - Entry of the wrong type, or during resistor calibration, aborts.
// - More than fifty entries without success aborts.
// - Current completion with uncalibrated resistor applies constants, flag stays clear.
// - Completion puts constants into working use only, never non-volatile storage.
// - Any other command discards partial calibration, constants untouched.
// - Per-channel current and voltage calibrated status words, bit n is channel n+1.
//
// Constants, opcodes and carriers of the calibration sequencer.
// Assumes a single 125 MHz clock domain shared with the AXI4-Lite master.
package dccs_pkg;
    localparam int DCCS_NCH = 16;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_VALUE = 8'h08;
    localparam logic [7:0] ADDR_REPLY = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CURCAL = 8'h14;
    localparam logic [7:0] ADDR_VOLCAL = 8'h18;
    localparam int CTRL_PATH_BIT = 0;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_CH_LSB = 8;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_ACT_LSB = 1;
    localparam int STAT_CNT_LSB = 8;
    localparam logic [5:0] MIN_ENTRIES = 6'h09;
    localparam logic [5:0] MAX_ENTRIES = 6'h32;
    localparam logic [4:0] CH_MAX_NARROW = 5'h08;
    localparam logic [4:0] CH_MAX_WIDE = 5'h10;
    localparam logic [15:0] RPL_NOT_READY = 16'h0000;
    localparam logic [15:0] RPL_READY = 16'h0001;
    localparam logic [15:0] RPL_DONE_RES = 16'h0000;
    localparam logic [15:0] RPL_MORE_RES = 16'h0001;
    localparam logic [15:0] RPL_DONE_NORES = 16'h0002;
    localparam logic [15:0] RPL_MORE_NORES = 16'h0003;
    localparam logic [15:0] RPL_ABORT = 16'h0005;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_CFG_CUR = 3'b001,
        OP_CFG_VOL = 3'b010,
        OP_ENT_CUR = 3'b011,
        OP_ENT_VOL = 3'b100,
        OP_OTHER = 3'b111
    } dccs_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CUR = 2'b01,
        ST_VOL = 2'b10
    } dccs_state_t;

    // Strap and neighbour levels; all asynchronous to clk_sys
    typedef struct packed {
        logic [DCCS_NCH-1:0] progSel;
        logic [DCCS_NCH-1:0] outIsVolt;
        logic trigWaiting;
        logic resCalActive;
        logic resCalibrated;
        logic fitConverged;
        logic wideBuild;
    } dccs_pins_t;

    typedef struct packed {
        logic strobe;
        logic isVolt;
        logic [3:0] chan;
        logic [31:0] lastValue;
    } dccs_apply_t;

    typedef struct packed {
        logic sharedConnect;
        logic [DCCS_NCH-1:0] chanClose;
    } dccs_route_t;
endpackage

// [tb/dccs_pin_model.sv]
// Far-side model: jumper straps and neighbour-block levels for the sequencer.
// Assumes the bench sets each level just after a clock edge and lets it settle.
`timescale 1ns/1ps
module dccs_pin_model
    import dccs_pkg::*;
(
    input wire logic [DCCS_NCH-1:0] progSel,
    input wire logic [DCCS_NCH-1:0] outIsVolt,
    input wire logic trigWaiting,
    input wire logic resCalActive,
    input wire logic resCalibrated,
    input wire logic fitConverged,
    input wire logic wideBuild,
    output dccs_pins_t pinsOut
);
    // Straps are static levels; they never float, so no idle pattern is needed
    assign pinsOut = {progSel, outIsVolt, trigWaiting, resCalActive, resCalibrated,
        fitConverged, wideBuild};
endmodule // dccs_pin_model

// [tb/test_dccs_cal_seq.sv]
// Self-checking bench for the calibration sequencer, AXI4-Lite master inside.
// Assumes the pin model drives the straps and a reference model tracks state.
`timescale 1ns/1ps
module test_dccs_cal_seq
    import dccs_pkg::*;
;
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] awAddr = 8'h00;
    logic [7:0] arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    logic [DCCS_NCH-1:0] pProg = '1, pVolt = '0;
    logic pTrig = 1'h0, pResAct = 1'h0, pResCal = 1'h1, pFit = 1'h1, pWide = 1'h1;
    dccs_pins_t pins;
    dccs_apply_t apply, seenApply;
    dccs_route_t route;
    int err_count = 0, tests_run = 0, seed = 66588, nStrobe = 0;
    int mState = 0, mCount = 0, mChan = 1, mErr = 0, mPath = 0, mStrobe = 0, mRep = 0;
    logic [15:0] mCur = '0, mVol = '0;
    logic [31:0] mVal = '0;

    always #4 clk_sys = ~clk_sys;

    dccs_pin_model PINS (.progSel(pProg), .outIsVolt(pVolt), .trigWaiting(pTrig),
        .resCalActive(pResAct), .resCalibrated(pResCal), .fitConverged(pFit),
        .wideBuild(pWide), .pinsOut(pins));

    dccs_cal_seq DUT (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .pinsIn(pins), .applyOut(apply), .routeOut(route));

    always @(posedge clk_sys) begin
        if (resetn && apply.strobe === 1'h1) begin
            nStrobe <= nStrobe + 1;
            seenApply <= apply;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Ready is sampled at the falling edge; it cannot change before the next rise
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw = 0;
        bit w = 0;
        bit b = 0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'h1;
        wValid <= 1'h1;
        bReady <= 1'h1;
        // Only the watchdog ends a wait that never gets an answer
        while (!b) begin
            @(negedge clk_sys);
            aw = awValid && awReady;
            w = wValid && wReady;
            b = bValid;
            r = bResp;
            @(posedge clk_sys);
            if (aw) awValid <= 1'h0;
            if (w) wValid <= 1'h0;
        end
        bReady <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar = 0;
        bit rv = 0;
        arAddr <= a;
        arValid <= 1'h1;
        rReady <= 1'h1;
        while (!rv) begin
            @(negedge clk_sys);
            ar = arValid && arReady;
            rv = rValid;
            d = rData;
            r = rResp;
            @(posedge clk_sys);
            if (ar) arValid <= 1'h0;
        end
        rReady <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic model(input int op, input int ch, output int rep);
        bit ok;
        ok = ch >= 1 && ch <= (pWide ? 16 : 8);
        // Commands other than configure or entry leave the reply as it stood
        rep = mRep;
        if (op == 1 || op == 2) begin
            rep = 0;
            mState = 0;
            mCount = 0;
            if (!ok || pTrig) mErr = 1;
            else if (pProg[ch-1] || pVolt[ch-1] == (op == 2)) begin
                rep = 1;
                mState = op;
                mChan = ch;
            end else mErr = 1;
        end else if (op == 3 || op == 4) begin
            rep = 5;
            if (!ok) mErr = 1;
            if (mState == op - 2 && !pResAct && ch == mChan && mCount < 50) begin
                mCount++;
                rep = (op == 4 || pResCal) ? 1 : 3;
                if (mCount >= 9 && pFit) begin
                    rep = rep - 1;
                    mStrobe++;
                    if (op == 3) mCur[ch-1] = pResCal;
                    else mVol[ch-1] = 1'h1;
                end
            end
            if (rep != 1 && rep != 3) mState = 0;
        end else mState = 0;
        if (mState == 0) mCount = 0;
        mRep = rep;
    endtask

    task automatic cmd(input int op, input int ch);
        int rep;
        int expR;
        logic [31:0] d;
        logic [1:0] r;
        real v;
        if (op == 3 || op == 4) begin
            v = ($random(seed) & 32'hFFFF) / 65535.0 * (op == 3 ? 6.0 : 19.2);
            mVal = $shortrealtobits(shortreal'(v));
            axi_wr(ADDR_VALUE, mVal, r);
            check(32'(r), 32'(RESP_OKAY));
        end
        axi_wr(ADDR_CMD, 32'((ch << CMD_CH_LSB) | op), r);
        check(32'(r), 32'(RESP_OKAY));
        model(op, ch, rep);
        expR = mState == 0 ? 0 : (mPath != 0 ? 1 << (mChan - 1) : 1 << DCCS_NCH);
        axi_rd(ADDR_REPLY, d, r);
        check(d, 32'(rep));
        axi_rd(ADDR_STATUS, d, r);
        check(d, 32'((mCount << STAT_CNT_LSB) | (mState << STAT_ACT_LSB) | mErr));
        axi_rd(ADDR_CURCAL, d, r);
        check(d, 32'(mCur));
        axi_rd(ADDR_VOLCAL, d, r);
        check(d, 32'(mVol));
        check(32'(route), 32'(expR));
        check(32'(nStrobe), 32'(mStrobe));
        if ((op == 3 || op == 4) && (rep == 0 || rep == 2)) begin
            check(seenApply.lastValue, mVal);
            check(32'({seenApply.isVolt, seenApply.chan}), 32'({op == 4, 4'(mChan - 1)}));
        end
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] regs [5] = '{ADDR_CTRL, ADDR_REPLY, ADDR_STATUS, ADDR_CURCAL, ADDR_VOLCAL};
        int ops [4] = '{0, 5, 6, 7};
        repeat (5) @(posedge clk_sys);
        resetn <= 1'h1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            axi_rd(regs[i], d, r);
            check(d, 32'h0);
        end
        check(32'(route), 32'h0);
        axi_rd(8'h1C, d, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_wr(8'h20, 32'h0, r);
        check(32'(r), 32'(RESP_SLVERR));
        cmd(1, 0);
        cmd(2, 17);
        axi_wr(ADDR_STATUS, 32'h1, r);
        mErr = 0;
        cmd(7, 1);
        pWide <= 1'h0;
        repeat (3) @(posedge clk_sys);
        cmd(1, 9);
        // entries until the code says complete
        cmd(1, 8);
        repeat (9) cmd(3, 8);
        pWide <= 1'h1;
        axi_wr(ADDR_CTRL, 32'h1, r);
        mPath = 1;
        cmd(2, 16);
        repeat (9) cmd(4, 16);
        pTrig <= 1'h1;
        repeat (3) @(posedge clk_sys);
        cmd(2, 3);
        pTrig <= 1'h0;
        pProg[2] <= 1'h0;
        pVolt[2] <= 1'h1;
        repeat (3) @(posedge clk_sys);
        cmd(1, 3);
        cmd(2, 3);
        cmd(3, 3);
        cmd(4, 3);
        for (int k = 1; k >= 0; k--) begin
            pResCal <= 1'(k);
            repeat (3) @(posedge clk_sys);
            cmd(1, 5);
            repeat (9) cmd(3, 5);
        end
        pFit <= 1'h0;
        repeat (3) @(posedge clk_sys);
        cmd(2, 1);
        repeat (51) cmd(4, 1);
        pFit <= 1'h1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            cmd(1, 2);
            repeat (3) cmd(3, 2);
            cmd(ops[i], 2);
        end
        cmd(2, 2);
        cmd(4, 3);
        pResAct <= 1'h1;
        repeat (3) @(posedge clk_sys);
        cmd(1, 6);
        cmd(3, 6);
        pResAct <= 1'h0;
        repeat (3) @(posedge clk_sys);
        repeat (60) cmd(1 + ($random(seed) & 3), ($random(seed) & 31) % 18);
        end_of_test();
    end
endmodule // test_dccs_cal_seq
